// ---- hdl/brs_sequencer.sv ----
// board reset sequencer: power-up, hard and soft reset control
// assumes standby-powered clock and a standby monitor driving rst_i
`timescale 1ns/10ps
`include "brs_cfg.svh"

module brs_sequencer #(
    parameter logic [`BRS_CNT_W-1:0] HOLD_CYC = `BRS_CNT_W'(`BRS_HOLD_CYC)
) (
    // clock and standby reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    // pins from supply, panel and reset sources
    input  wire logic                  supply_power_good_i,
    input  wire logic                  panel_reset_n_i,
    input  wire logic                  sb_soft_reset_i,
    input  wire logic                  debug_probe_port_reset_i,
    input  wire logic                  cpu_soft_reset_i,
    input  wire logic                  super_io_device_reset_i,
    input  wire logic                  soft_src_clear_i,
    // outputs to processors and southbridge
    output logic                       processor_power_good_o,
    output logic                       cpu_init_o,
    output logic                       hard_reset_active_o,
    output logic [`BRS_SRC_W-1:0]      soft_src_o
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // soft request bits sit low, then the panel press, then supply pg
    localparam int NIN       = `BRS_SRC_W + 2;
    localparam int PANEL_BIT = `BRS_SRC_W;
    localparam int PG_BIT    = `BRS_SRC_W + 1;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    // press is inverted here so it idles at zero like the soft request synchronisers
    assign raw = {supply_power_good_i,
                  ~panel_reset_n_i,
                  super_io_device_reset_i,
                  cpu_soft_reset_i,
                  debug_probe_port_reset_i,
                  sb_soft_reset_i};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    logic                  pg_s;
    logic                  panel_s;
    logic [`BRS_SRC_W-1:0] soft_s;
    assign pg_s    = s2_q[PG_BIT];
    assign panel_s = s2_q[PANEL_BIT];
    assign soft_s  = s2_q[`BRS_SRC_W-1:0];

    // ----------------------------------------------------------------
    // edge detect on synchronised levels
    // ----------------------------------------------------------------
    logic                  panel_d1_q;
    logic [`BRS_SRC_W-1:0] soft_d1_q;
    logic                  panel_rise;
    logic [`BRS_SRC_W-1:0] soft_rise;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            panel_d1_q <= 1'b0;
        end else begin
            panel_d1_q <= panel_s;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            soft_d1_q <= '0;
        end else begin
            soft_d1_q <= soft_s;
        end
    end
    assign panel_rise = panel_s & ~panel_d1_q;
    assign soft_rise  = soft_s & ~soft_d1_q;

    // ----------------------------------------------------------------
    // sequencing state machine
    // ----------------------------------------------------------------
    // rst_i or a low synchronised supply pg clears this state; a panel reset merely re-enters HOLD
    brs_pkg::brs_state_t   state_q;
    logic [`BRS_CNT_W-1:0] cnt_q;
    logic                  hard_q;
    logic                  hold_done;
    logic                  in_run;

    assign hold_done = (state_q == brs_pkg::BRS_HOLD) &&
                       (cnt_q == HOLD_CYC - 1'b1);
    assign in_run    = (state_q == brs_pkg::BRS_RUN);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= brs_pkg::BRS_WAIT_SUPPLY;
        end else if (!pg_s) begin
            state_q <= brs_pkg::BRS_WAIT_SUPPLY;
        end else begin
            case (state_q)
                brs_pkg::BRS_WAIT_SUPPLY: begin
                    state_q <= brs_pkg::BRS_HOLD;
                end
                brs_pkg::BRS_HOLD: begin
                    // a press here is ignored: the hold already runs
                    if (hold_done) begin
                        state_q <= brs_pkg::BRS_RUN;
                    end
                end
                brs_pkg::BRS_RUN: begin
                    if (panel_rise) begin
                        state_q <= brs_pkg::BRS_HOLD;
                    end
                end
                default: begin
                    state_q <= brs_pkg::BRS_WAIT_SUPPLY;
                end
            endcase
        end
    end

    // counter idles at zero, so every entry into the hold starts afresh
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (!pg_s || state_q != brs_pkg::BRS_HOLD) begin
            cnt_q <= '0;
        end else if (!hold_done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // marks a panel hard reset from the press to the end of its hold
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hard_q <= 1'b0;
        end else if (!pg_s) begin
            hard_q <= 1'b0;
        end else if (in_run && panel_rise) begin
            hard_q <= 1'b1;
        end else if (hold_done) begin
            hard_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // southbridge derives its bus reset pulse from this edge
    // the press itself drops power-good on the same edge that enters the hold state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            processor_power_good_o <= 1'b0;
        end else begin
            processor_power_good_o <= pg_s && in_run
                                      && !panel_rise;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hard_reset_active_o <= 1'b0;
        end else begin
            hard_reset_active_o <= hard_q;
        end
    end

    // soft reset: init pulse only, power-good untouched so caches stay
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cpu_init_o <= 1'b0;
        end else begin
            cpu_init_o <= (|soft_rise)
                          && in_run;
        end
    end

    logic soft_clear_q;

    // sticky source record; a new request wins over the clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            soft_src_o <= '0;
        end else begin
            soft_src_o <= (soft_clear_q ? '0 : soft_src_o)
                          | soft_rise;
        end
    end

    // clear is a same-clock level, registered once before use
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            soft_clear_q <= 1'b0;
        end else begin
            soft_clear_q <= soft_src_clear_i;
        end
    end

endmodule : brs_sequencer

// ---- hdl/brs_cfg.svh ----
// board reset sequencer constants
// assumes a 40 MHz system clock on standby power
`ifndef BRS_CFG_SVH
`define BRS_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BRS_CLK_HZ        40000000
`define BRS_HOLD_MS       500
`define BRS_HOLD_CYC      ((`BRS_CLK_HZ / 1000) * `BRS_HOLD_MS)
`define BRS_CNT_W         25

// ----------------------------------------------------------------
// soft reset source bit positions
// ----------------------------------------------------------------
`define BRS_SRC_SB        0
`define BRS_SRC_PROBE     1
`define BRS_SRC_CPU       2
`define BRS_SRC_SUPER_IO  3
`define BRS_SRC_W         4

`endif

// ---- hdl/brs_pkg.sv ----
// board reset sequencer types
// assumes brs_cfg.svh holds the numeric constants
package brs_pkg;

    typedef enum logic [1:0] {
        BRS_WAIT_SUPPLY,
        BRS_HOLD,
        BRS_RUN
    } brs_state_t;

endpackage : brs_pkg

// ---- sim/brs_sequencer_asserts.sv ----
// port checker for the board reset sequencer
// assumes it is bound to every sequencer instance
`timescale 1ns/10ps
`include "brs_cfg.svh"
module brs_sequencer_asserts #(
    parameter logic [`BRS_CNT_W-1:0] HOLD_CYC = `BRS_CNT_W'(`BRS_HOLD_CYC)
) (
    // clock and standby reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    // watched pins
    input  wire logic                  supply_power_good_i,
    input  wire logic                  panel_reset_n_i,
    input  wire logic                  sb_soft_reset_i,
    input  wire logic                  soft_src_clear_i,
    // watched outputs
    input  wire logic                  processor_power_good_o,
    input  wire logic                  cpu_init_o,
    input  wire logic                  hard_reset_active_o,
    input  wire logic [`BRS_SRC_W-1:0] soft_src_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    // saturating run lengths of supply high and power-good low
    logic [`BRS_CNT_W-1:0] up_q;
    logic [`BRS_CNT_W-1:0] low_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !supply_power_good_i) begin
            up_q <= '0;
        end else if (~&up_q) begin
            up_q <= up_q + 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || processor_power_good_o) begin
            low_q <= '0;
        end else if (~&low_q) begin
            low_q <= low_q + 1'b1;
        end
    end

    sequence s_press;
        $fell(panel_reset_n_i) && processor_power_good_o
            && !hard_reset_active_o;
    endsequence
    sequence s_held;
        !processor_power_good_o && hard_reset_active_o;
    endsequence

    property p_rst;
        $fell(rst_i) |-> !processor_power_good_o && !cpu_init_o
            && !hard_reset_active_o && soft_src_o == '0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("output after reset");
    property p_hold;
        $rose(processor_power_good_o) |->
            up_q >= HOLD_CYC && low_q >= HOLD_CYC - 1'b1;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold too short");
    property p_up;
        up_q == HOLD_CYC + 8 && !hard_reset_active_o
            |-> processor_power_good_o;
    endproperty
    a_up: assert property (p_up)
        else $error("power-good late");
    property p_panel;
        s_press |-> ##[2:6] s_held;
    endproperty
    a_panel: assert property (p_panel)
        else $error("no hard reset");
    property p_loss;
        $fell(supply_power_good_i) |-> ##[1:6] !processor_power_good_o;
    endproperty
    a_loss: assert property (p_loss)
        else $error("no drop on loss");
    property p_init;
        cpu_init_o |=> !cpu_init_o;
    endproperty
    a_init: assert property (p_init)
        else $error("init too long");
    property p_src;
        $rose(sb_soft_reset_i) |-> ##[2:6] soft_src_o[0];
    endproperty
    a_src: assert property (p_src)
        else $error("source lost");
    property p_sticky;
        !$past(soft_src_clear_i) && !$past(soft_src_clear_i, 2)
            |-> ($past(soft_src_o) & ~soft_src_o) == '0;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("bit dropped");
endmodule : brs_sequencer_asserts
bind brs_sequencer brs_sequencer_asserts #(.HOLD_CYC(HOLD_CYC)) CHK (.*);

// ---- sim/brs_board_model.sv ----
// supply and southbridge model
// assumes volts_ok_i is driven off the clock edge
`timescale 1ns/10ps
module brs_board_model (
    // clock and board level stimulus
    input  wire logic sys_clk_i,
    input  wire logic volts_ok_i,
    // from the sequencer
    input  wire logic processor_power_good_i,
    // supply and southbridge outputs
    output logic      supply_power_good_o,
    output logic      bus_reset_o
);
    logic [2:0] ok_q = 3'h0;
    logic       pg_q = 1'b0;
    always @(posedge sys_clk_i) ok_q <= {ok_q[1:0], volts_ok_i};
    always @(posedge sys_clk_i) pg_q <= processor_power_good_i;
    assign supply_power_good_o = &ok_q;
    assign bus_reset_o = processor_power_good_i & ~pg_q;
endmodule : brs_board_model

// ---- sim/tb.sv ----
// self-checking bench for the board reset sequencer
// assumes the hold is shortened to 20 cycles
`timescale 1ns/10ps
module tb;
    localparam int H = 20;
    logic clk = 1'b0, rst = 1'b1, ok = 1'b0, pnl = 1'b1, clr = 1'b0;
    logic [3:0] req = 4'h0, src;
    logic       spg, ppg, init, hard, bus;
    int num_errors = 0, check_count = 0, n_init = 0, seed = 32'hc363, i, k;
    logic [3:0] exp_src = 4'h0;
    initial forever #12.5 clk = ~clk;
    int n_bus = 0;
    always @(negedge clk) if (init === 1'b1) n_init++;
    always @(negedge clk) if (bus === 1'b1) n_bus++;
    brs_board_model BRD (.sys_clk_i(clk), .volts_ok_i(ok),
        .processor_power_good_i(ppg), .supply_power_good_o(spg),
        .bus_reset_o(bus));
    brs_sequencer #(.HOLD_CYC(25'h14)) DUT (.sys_clk_i(clk), .rst_i(rst),
        .supply_power_good_i(spg), .panel_reset_n_i(pnl),
        .sb_soft_reset_i(req[0]), .debug_probe_port_reset_i(req[1]),
        .cpu_soft_reset_i(req[2]), .super_io_device_reset_i(req[3]),
        .soft_src_clear_i(clr), .processor_power_good_o(ppg),
        .cpu_init_o(init), .hard_reset_active_o(hard), .soft_src_o(src));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_pg(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (ppg !== v && n < hi) begin
            @(negedge clk);
            n++;
        end
        chk({3'h0, n >= lo && n < hi}, 4'h1);
    endtask : wait_pg
    task automatic pulse(input int b);
        req[b] = 1'b1;
        repeat (4) @(negedge clk);
        req[b] = 1'b0;
        repeat (4) @(negedge clk);
    endtask : pulse
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        #(25 * 4000);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        ok = 1'b1;
        wait_pg(1'b1, H + 2, H + 12);
        $display("power up done");
        for (i = 0; i < 6; i++) begin
            k = $unsigned($random(seed)) % 4;
            pulse(k);
            exp_src[k] = 1'b1;
        end
        chk(src, exp_src);
        chk(4'(n_init), 4'h6);
        $display("soft reset done");
        pnl = 1'b0;
        wait_pg(1'b0, 0, 8);
        @(negedge clk);
        chk({3'h0, hard}, 4'h1);
        pnl = 1'b1;
        wait_pg(1'b1, H - 4, H + 8);
        chk(src, exp_src);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (3) @(negedge clk);
        chk(src, 4'h0);
        $display("hard reset done");
        ok = 1'b0;
        wait_pg(1'b0, 0, 8);
        pulse(0);
        chk(src, 4'h1);
        chk(4'(n_init), 4'h6);
        ok = 1'b1;
        wait_pg(1'b1, H + 2, H + 14);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        chk({src[2:0], ppg}, 4'h0);
        chk(4'(n_bus), 4'h3);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk({hard, src[2:0]}, 4'h0);
        $display("supply loss done");
        test_done();
    end
endmodule : tb
